// *** itt_master_tx.sv ***
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module itt_master_tx #(
    parameter int QTR_CYC  = itt_pkg::QTR_CYC,
    parameter int FREE_CYC = itt_pkg::FREE_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [5:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [5:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Serial clock, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    // Serial data, open drain
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        logic [1:0]         scl_s;
        logic [1:0]         sda_s;
        logic [8:0]         free_cnt;
        logic               bus_free;
        itt_pkg::itt_state_t st;
        itt_pkg::itt_kind_t kind;
        logic [7:0]         qcnt;
        logic [1:0]         ph;
        logic [2:0]         bitn;
        logic [7:0]         shift;
        logic               scl_lo;
        logic               sda_lo;
        logic               en;
        logic               start;
        logic               abd;
        logic               master_data_request;
        logic [7:0]         cnt;
        logic [7:0]         adb0;
        logic [7:0]         adb1;
        logic [7:0]         txb;
        logic               txfull;
        logic [3:0]         sts;
        logic [3:0]         ien;
        logic               aw_ok;
        logic [5:0]         awaddr;
        logic               w_ok;
        logic [7:0]         wdata;
        logic               wstrb0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } itt_regs_t;

    itt_regs_t q_reg;
    itt_regs_t q_next;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic itt_mapped(input logic [5:0] a);
        itt_mapped = (a[1:0] == 2'h0) && (a <= itt_pkg::OFS_IRQ_ENABLE);
    endfunction : itt_mapped

    function automatic logic [7:0] itt_read(input itt_regs_t r,
                                            input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            itt_pkg::OFS_MAIN_CTRL: begin
                v[itt_pkg::BIT_ENABLE]   = r.en;
                v[itt_pkg::BIT_START]    = r.start;
                v[itt_pkg::BIT_DATA_REQ] = r.master_data_request;
            end
            itt_pkg::OFS_EXT_CTRL:
                v[itt_pkg::BIT_ADDR_BUF_D] = r.abd;
            itt_pkg::OFS_BYTE_COUNT: v = r.cnt;
            itt_pkg::OFS_LOW_ADDR:   v = r.adb0;
            itt_pkg::OFS_HIGH_ADDR:  v = r.adb1;
            itt_pkg::OFS_TX_BUFFER:  v = r.txb;
            itt_pkg::OFS_BUF_STATUS:
                v[itt_pkg::BIT_TX_EMPTY] = ~r.txfull;
            itt_pkg::OFS_BUS_STATUS: begin
                v[itt_pkg::BIT_BUS_FREE]   = r.bus_free;
                v[itt_pkg::BIT_MASTER_ACT] = (r.st != itt_pkg::ST_IDLE);
            end
            itt_pkg::OFS_IRQ_STATUS: v = {4'h0, r.sts};
            itt_pkg::OFS_IRQ_ENABLE: v = {4'h0, r.ien};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : itt_read

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       qdone;
        logic       wr;
        logic       need_tx;
        logic [3:0] evt;
        logic [3:0] clr;
        qdone   = 1'b0;
        wr      = 1'b0;
        need_tx = 1'b0;
        evt     = 4'h0;
        clr     = 4'h0;
        q_next  = q_reg;

        // Pins pass two flip-flops before use.
        q_next.scl_s = {q_reg.scl_s[0], scl_in};
        q_next.sda_s = {q_reg.sda_s[0], sda_in};

        // Bus is free once both lines stayed high long enough.
        if (!(q_reg.scl_s[1] && q_reg.sda_s[1])) begin
            q_next.free_cnt = 9'h000;
            q_next.bus_free = 1'b0;
        end else if (q_reg.free_cnt == 9'(FREE_CYC - 1)) begin
            q_next.bus_free = 1'b1;
        end else begin
            q_next.free_cnt = q_reg.free_cnt + 9'h001;
        end

        // Quarter-bit timer. It holds while a slave keeps the clock
        // low in the high phase of a bit or its acknowledge, so slow slaves are honoured.
        if (q_reg.ph[1] && !q_reg.scl_s[1] && q_reg.st != itt_pkg::ST_STOP
            && q_reg.st != itt_pkg::ST_START) begin
            q_next.qcnt = q_reg.qcnt;
        end else if (q_reg.qcnt == 8'(QTR_CYC - 1)) begin
            q_next.qcnt = 8'h00;
            qdone       = 1'b1;
        end else begin
            q_next.qcnt = q_reg.qcnt + 8'h01;
        end

        // AXI4-Lite write channels, taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            q_next.aw_ok  = 1'b1;
            q_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            q_next.w_ok   = 1'b1;
            q_next.wdata  = s_axi_wdata[7:0];
            q_next.wstrb0 = s_axi_wstrb[0];
        end
        if (q_reg.aw_ok && q_reg.w_ok && !q_reg.bvalid) begin
            wr            = q_reg.wstrb0 && itt_mapped(q_reg.awaddr);
            q_next.aw_ok  = 1'b0;
            q_next.w_ok   = 1'b0;
            q_next.bvalid = 1'b1;
            q_next.bresp  = itt_mapped(q_reg.awaddr) ?
                            itt_pkg::RESP_OKAY : itt_pkg::RESP_SERR;
        end
        if (q_reg.bvalid && s_axi_bready) begin
            q_next.bvalid = 1'b0;
        end

        if (wr) begin
            case (q_reg.awaddr)
                itt_pkg::OFS_MAIN_CTRL: begin
                    q_next.en = q_reg.wdata[itt_pkg::BIT_ENABLE];
                    if (!q_reg.abd && q_reg.wdata[itt_pkg::BIT_START]) begin
                        q_next.start = 1'b1;
                    end
                end
                itt_pkg::OFS_EXT_CTRL:
                    q_next.abd = q_reg.wdata[itt_pkg::BIT_ADDR_BUF_D];
                itt_pkg::OFS_BYTE_COUNT: q_next.cnt  = q_reg.wdata;
                itt_pkg::OFS_LOW_ADDR:   q_next.adb0 = q_reg.wdata;
                itt_pkg::OFS_HIGH_ADDR:  q_next.adb1 = q_reg.wdata;
                itt_pkg::OFS_TX_BUFFER: begin
                    q_next.txb    = q_reg.wdata;
                    q_next.txfull = 1'b1;
                    if (q_reg.abd && q_reg.en
                        && q_reg.st == itt_pkg::ST_IDLE) begin
                        q_next.start = 1'b1;
                    end
                end
                itt_pkg::OFS_IRQ_CLEAR:  clr = q_reg.wdata[3:0];
                itt_pkg::OFS_IRQ_ENABLE: q_next.ien = q_reg.wdata[3:0];
                default: ;
            endcase
        end

        // AXI4-Lite read, answered one cycle after the address.
        if (s_axi_arvalid && s_axi_arready) begin
            q_next.rvalid = 1'b1;
            q_next.rdata  = {24'h000000, itt_read(q_reg, s_axi_araddr)};
            q_next.rresp  = itt_mapped(s_axi_araddr) ?
                            itt_pkg::RESP_OKAY : itt_pkg::RESP_SERR;
        end else if (q_reg.rvalid && s_axi_rready) begin
            q_next.rvalid = 1'b0;
        end

        // Sequencer.
        if (qdone) begin
            q_next.ph = q_reg.ph + 2'h1;
        end
        case (q_reg.st)
            itt_pkg::ST_IDLE: begin
                q_next.scl_lo = 1'b0;
                q_next.sda_lo = 1'b0;
                if (q_reg.en && q_reg.start) begin
                    q_next.st = itt_pkg::ST_WAIT_FREE;
                end
            end
            itt_pkg::ST_WAIT_FREE: begin
                if (q_reg.bus_free) begin
                    q_next.st    = itt_pkg::ST_START;
                    q_next.kind  = itt_pkg::KIND_HIGH;
                    q_next.ph    = 2'h0;
                    q_next.qcnt  = 8'h00;
                    q_next.start = 1'b0;
                    if (q_reg.abd) begin
                        q_next.shift  = q_reg.txb;
                        q_next.txfull = 1'b0;
                    end else begin
                        q_next.shift = q_reg.adb1;
                    end
                end
            end
            itt_pkg::ST_START: begin
                q_next.sda_lo = 1'b1;
                q_next.scl_lo = q_next.ph[1];
                if (qdone && q_reg.ph == 2'h2) begin
                    q_next.st   = itt_pkg::ST_BIT;
                    q_next.ph   = 2'h0;
                    q_next.bitn = 3'h7;
                end
            end
            itt_pkg::ST_BIT: begin
                q_next.scl_lo = ~q_next.ph[1];
                if (q_reg.ph == 2'h0) begin
                    q_next.sda_lo = ~q_reg.shift[7];
                end
                if (qdone && q_reg.ph == 2'h3) begin
                    if (q_reg.bitn != 3'h0) begin
                        q_next.bitn  = q_reg.bitn - 3'h1;
                        q_next.shift = {q_reg.shift[6:0], 1'b0};
                    end else begin
                        need_tx = (q_reg.kind == itt_pkg::KIND_HIGH)
                                ? q_reg.abd : (q_reg.cnt != 8'h00);
                        if (need_tx && !q_reg.txfull) begin
                            q_next.st  = itt_pkg::ST_STRETCH;
                            q_next.master_data_request = 1'b1;
                            evt[itt_pkg::IRQ_TX] = 1'b1;
                        end else begin
                            q_next.st = itt_pkg::ST_ACK;
                        end
                    end
                end
            end
            itt_pkg::ST_STRETCH: begin
                q_next.scl_lo = 1'b1;
                q_next.ph     = 2'h0;
                q_next.qcnt   = 8'h00;
                if (q_reg.txfull) begin
                    q_next.master_data_request = 1'b0;
                    q_next.st  = itt_pkg::ST_ACK;
                end
            end
            itt_pkg::ST_ACK: begin
                q_next.scl_lo = ~q_next.ph[1];
                q_next.sda_lo = 1'b0;
                q_next.bitn   = 3'h7;
                if (qdone && q_reg.ph == 2'h3) begin
                    q_next.st = itt_pkg::ST_BIT;
                    if (q_reg.sda_s[1]) begin
                        q_next.st = itt_pkg::ST_STOP;
                        evt[itt_pkg::IRQ_NACK] = 1'b1;
                    end else if (q_reg.kind == itt_pkg::KIND_HIGH) begin
                        q_next.kind = itt_pkg::KIND_LOW;
                        if (q_reg.abd) begin
                            q_next.shift  = q_reg.txb;
                            q_next.txfull = 1'b0;
                        end else begin
                            q_next.shift = q_reg.adb0;
                        end
                    end else if (q_reg.cnt == 8'h00) begin
                        q_next.st = itt_pkg::ST_STOP;
                        evt[itt_pkg::IRQ_COUNT_DONE] = 1'b1;
                    end else begin
                        q_next.kind   = itt_pkg::KIND_DATA;
                        q_next.shift  = q_reg.txb;
                        q_next.txfull = 1'b0;
                        q_next.cnt    = q_reg.cnt - 8'h01;
                    end
                end
            end
            itt_pkg::ST_STOP: begin
                q_next.scl_lo = (q_next.ph == 2'h0);
                q_next.sda_lo = ~q_next.ph[1];
                if (qdone && q_reg.ph == 2'h2) begin
                    q_next.st = itt_pkg::ST_IDLE;
                    q_next.ph = 2'h0;
                    evt[itt_pkg::IRQ_STOP] = 1'b1;
                end
            end
            default: q_next.st = itt_pkg::ST_IDLE;
        endcase

        // Disabling the block drops any transfer and frees the lines.
        if (!q_reg.en) begin
            q_next.st     = itt_pkg::ST_IDLE;
            q_next.master_data_request    = 1'b0;
            q_next.scl_lo = 1'b0;
            q_next.sda_lo = 1'b0;
        end

        // A new event wins over a clear in the same cycle.
        q_next.sts = (q_reg.sts & ~clr) | evt;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q_reg          <= '0;
            q_reg.scl_s    <= 2'h3;
            q_reg.sda_s    <= 2'h3;
            q_reg.st       <= itt_pkg::ST_IDLE;
            q_reg.kind     <= itt_pkg::KIND_HIGH;
            q_reg.cnt      <= itt_pkg::RST_BYTE;
            q_reg.adb0     <= itt_pkg::RST_BYTE;
            q_reg.adb1     <= itt_pkg::RST_BYTE;
            q_reg.txb      <= itt_pkg::RST_BYTE;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !q_reg.aw_ok && !q_reg.bvalid;
    assign s_axi_wready  = !q_reg.w_ok && !q_reg.bvalid;
    assign s_axi_bvalid  = q_reg.bvalid;
    assign s_axi_bresp   = q_reg.bresp;
    assign s_axi_arready = !q_reg.rvalid;
    assign s_axi_rvalid  = q_reg.rvalid;
    assign s_axi_rdata   = q_reg.rdata;
    assign s_axi_rresp   = q_reg.rresp;
    assign scl_out       = 1'b0;
    assign scl_oe        = q_reg.scl_lo;
    assign sda_out       = 1'b0;
    assign sda_oe        = q_reg.sda_lo;
    assign irq           = |(q_reg.sts & q_reg.ien);

endmodule : itt_master_tx
`default_nettype wire

// *** itt_pkg.sv ***
package itt_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_MAIN_CTRL  = 6'h00;
    localparam logic [5:0] OFS_EXT_CTRL   = 6'h04;
    localparam logic [5:0] OFS_BYTE_COUNT = 6'h08;
    localparam logic [5:0] OFS_LOW_ADDR   = 6'h0C;
    localparam logic [5:0] OFS_HIGH_ADDR  = 6'h10;
    localparam logic [5:0] OFS_TX_BUFFER  = 6'h14;
    localparam logic [5:0] OFS_BUF_STATUS = 6'h18;
    localparam logic [5:0] OFS_BUS_STATUS = 6'h1C;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h20;
    localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h24;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE     = 7;
    localparam int BIT_START      = 5;
    localparam int BIT_DATA_REQ   = 3;
    localparam int BIT_ADDR_BUF_D = 4;
    localparam int BIT_TX_EMPTY   = 5;
    localparam int BIT_BUS_FREE   = 7;
    localparam int BIT_MASTER_ACT = 5;
    localparam int IRQ_TX         = 0;
    localparam int IRQ_COUNT_DONE = 1;
    localparam int IRQ_NACK       = 2;
    localparam int IRQ_STOP       = 3;
    localparam int IRQ_W          = 4;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SERR = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS      = 4;
    localparam int SCL_QTR_NS  = 625;
    localparam int BUS_FREE_NS = 1300;
    localparam int QTR_CYC     = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int FREE_CYC    = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // Sequencer states and byte kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_FREE, ST_START, ST_BIT,
        ST_STRETCH, ST_ACK, ST_STOP
    } itt_state_t;

    typedef enum logic [1:0] {
        KIND_HIGH, KIND_LOW, KIND_DATA
    } itt_kind_t;

endpackage : itt_pkg

// *** itt_master_tx_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module itt_master_tx_checker #(
    parameter int QTR_CYC = 4
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    // Link drivers
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    // Register bus answers
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid
);
    // Length of the present clock phase, saturated so it never wraps.
    logic [7:0] run_reg;
    logic       prev_reg;
    always_ff @(posedge clk_sys) begin
        prev_reg <= scl_oe;
        if (srst || scl_oe != prev_reg) begin
            run_reg <= 8'h01;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property ($fell(srst) |-> !scl_oe && !sda_oe
        && !s_axi_bvalid && !s_axi_rvalid) else $error("active after reset");
    a_free_wait: assert property ($fell(srst) |-> !sda_oe [*8])
        else $error("start before bus free");
    a_low_phase: assert property ($fell(scl_oe) |-> run_reg >= QTR_CYC)
        else $error("clock low phase too short");
    a_high_phase: assert property ($rose(scl_oe) |->
        run_reg >= 2 * QTR_CYC) else $error("clock high phase too short");
    a_start_shape: assert property ($rose(sda_oe) && !scl_oe |->
        !scl_oe [*4] ##[1:12] scl_oe) else $error("bad start shape");
    a_stop_idle: assert property ($fell(sda_oe) && !scl_oe |->
        (!sda_oe && !scl_oe) [*8]) else $error("lines not idle after stop");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
endmodule : itt_master_tx_checker
bind itt_master_tx itt_master_tx_checker #(.QTR_CYC(QTR_CYC)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// *** itt_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module itt_slave_model (
    // Bus lines
    input wire logic       scl,
    input wire logic       sda,
    output logic           scl_pull,
    output logic           sda_pull,
    // Behaviour
    input wire logic [3:0] nack_at,
    input wire logic       slow
);
    logic [7:0] shift = 8'h00;
    logic [7:0] got [0:7];
    int         bitn = 0;
    int         nbytes = 0;
    initial begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end
    always @(negedge sda) begin
        if (scl) begin
            bitn = -1;
            nbytes = 0;
            sda_pull = 1'h0;
        end
    end
    always @(posedge scl) begin
        if (bitn >= 0 && bitn < 8) shift = {shift[6:0], sda};
    end
    always @(negedge scl) begin
        if (bitn == 8) begin
            sda_pull = 1'h0;
            bitn = 0;
        end else begin
            bitn = bitn + 1;
            if (bitn == 8) begin
                got[nbytes] = shift;
                sda_pull = (nbytes != int'(nack_at));
                nbytes = nbytes + 1;
                // The slow case holds the clock low to test stretching.
                if (slow) begin
                    scl_pull = 1'h1;
                    #96;
                    scl_pull = 1'h0;
                end
            end
        end
    end
endmodule : itt_slave_model
`default_nettype wire

// *** i2c_master_tenbit_transmit_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module i2c_master_tenbit_transmit_tb_top;
    logic clk_sys = 1'h0, srst = 1'h1, slow = 1'h0;
    logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic [5:0] aw_a = 6'h00, ar_a = 6'h00;
    logic [31:0] w_d = 32'h0, r_d;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, scl_oe, sda_oe, s_scl, s_sda, irq;
    logic [1:0] b_resp, r_resp, rsp;
    logic [3:0] nack_at = 4'h8;
    int bad_count = 0, num_checks = 0;
    wire logic scl_w = !(scl_oe | s_scl);
    wire logic sda_w = !(sda_oe | s_sda);
    always #2 clk_sys = ~clk_sys;
    itt_master_tx #(.QTR_CYC(4), .FREE_CYC(8)) uut (
        .clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_bresp(b_resp),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_araddr(ar_a),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_resp), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    itt_slave_model u_slave (.scl(scl_w), .sda(sda_w), .scl_pull(s_scl),
        .sda_pull(s_sda), .nack_at(nack_at), .slow(slow));
    task automatic chk(input logic [7:0] s, input logic [7:0] e, string n);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        aw_a <= a;
        w_d <= {24'h0, d};
        aw_v <= 1'h1;
        w_v <= 1'h1;
        b_r <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (aw_rdy) aw_v <= 1'h0;
            if (w_rdy) w_v <= 1'h0;
        end while (b_v !== 1'h1);
        rsp = b_resp;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        ar_a <= a;
        ar_v <= 1'h1;
        r_r <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (ar_rdy) ar_v <= 1'h0;
        end while (r_v !== 1'h1);
        rsp = r_resp;
        d = r_d[7:0];
    endtask : rd
    task automatic rc(input logic [5:0] a, input logic [7:0] e, string n);
        logic [7:0] d;
        rd(a, d);
        chk(d, e, n);
    endtask : rc
    // Polls the sticky status until a bit of the mask shows up or 600 reads have passed.
    task automatic poll(input logic [7:0] m);
        logic [7:0] d;
        int n;
        d = 8'h00;
        n = 0;
        while ((d & m) == 8'h00 && n < 600) begin
            rd(itt_pkg::OFS_IRQ_STATUS, d);
            n++;
        end
    endtask : poll
    task automatic load(input logic [7:0] c, hi, lo, tx);
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h0F);
        wr(itt_pkg::OFS_EXT_CTRL, 8'h00);
        wr(itt_pkg::OFS_MAIN_CTRL, 8'h80);
        wr(itt_pkg::OFS_BYTE_COUNT, c);
        wr(itt_pkg::OFS_HIGH_ADDR, hi);
        wr(itt_pkg::OFS_LOW_ADDR, lo);
        wr(itt_pkg::OFS_TX_BUFFER, tx);
        wr(itt_pkg::OFS_MAIN_CTRL, 8'hA0);
    endtask : load
    task automatic t_regs;
        logic [7:0] d;
        rc(itt_pkg::OFS_BYTE_COUNT, 8'h00, "count reset");
        wr(itt_pkg::OFS_BYTE_COUNT, 8'hA5);
        rc(itt_pkg::OFS_BYTE_COUNT, 8'hA5, "count");
        rd(6'h3C, d);
        chk({6'h0, rsp}, {6'h0, itt_pkg::RESP_SERR}, "unmapped resp");
        chk(d, 8'h00, "unmapped data");
        wr(6'h3C, 8'h00);
        chk({6'h0, rsp}, {6'h0, itt_pkg::RESP_SERR}, "unmapped write");
        rc(itt_pkg::OFS_BUS_STATUS, 8'h80, "bus free");
        rc(itt_pkg::OFS_BUF_STATUS, 8'h20, "buffer empty");
        $display("test registers done");
    endtask : t_regs
    task automatic t_buf;
        slow = 1'h1;
        load(8'h02, 8'hF2, 8'h5A, 8'hC3);
        poll(8'h01);
        chk({7'h0, scl_w}, 8'h00, "stretched clock");
        rc(itt_pkg::OFS_MAIN_CTRL, 8'h88, "data request");
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h01);
        wr(itt_pkg::OFS_TX_BUFFER, 8'h3C);
        poll(8'h08);
        rc(itt_pkg::OFS_IRQ_STATUS, 8'h0A, "done and stop");
        rc(itt_pkg::OFS_BYTE_COUNT, 8'h00, "count left");
        chk(u_slave.got[1], 8'h5A, "low address");
        chk(u_slave.got[2], 8'hC3, "data one");
        chk(u_slave.got[3], 8'h3C, "data two");
        chk(8'(u_slave.nbytes), 8'h04, "bytes");
        slow = 1'h0;
        $display("test buffered done");
    endtask : t_buf
    task automatic t_unbuf;
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h0F);
        wr(itt_pkg::OFS_EXT_CTRL, 8'h10);
        wr(itt_pkg::OFS_BYTE_COUNT, 8'h01);
        wr(itt_pkg::OFS_MAIN_CTRL, 8'hA0);
        repeat (60) @(posedge clk_sys);
        rc(itt_pkg::OFS_MAIN_CTRL, 8'h80, "start ignored");
        chk({7'h0, sda_w}, 8'h01, "no start");
        wr(itt_pkg::OFS_TX_BUFFER, 8'hF0);
        poll(8'h01);
        rc(itt_pkg::OFS_MAIN_CTRL, 8'h88, "request");
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h01);
        wr(itt_pkg::OFS_TX_BUFFER, 8'h11);
        poll(8'h01);
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h01);
        wr(itt_pkg::OFS_TX_BUFFER, 8'h77);
        poll(8'h08);
        rc(itt_pkg::OFS_IRQ_STATUS, 8'h0A, "done and stop");
        chk(u_slave.got[0], 8'hF0, "high address");
        chk(u_slave.got[1], 8'h11, "low address");
        chk(u_slave.got[2], 8'h77, "data");
        $display("test unbuffered done");
    endtask : t_unbuf
    task automatic t_nack;
        wr(itt_pkg::OFS_IRQ_ENABLE, 8'h00);
        for (int i = 0; i < 2; i++) begin
            nack_at = (i == 0) ? 4'h0 : 4'h2;
            load(8'h01, 8'hF6, 8'h22, 8'h99);
            poll(8'h08);
            rc(itt_pkg::OFS_IRQ_STATUS, 8'h0C, "nack and stop");
            chk(8'(u_slave.nbytes), (i == 0) ? 8'h01 : 8'h03, "sent");
        end
        chk({7'h0, irq}, 8'h00, "masked irq");
        wr(itt_pkg::OFS_IRQ_ENABLE, 8'h04);
        chk({7'h0, irq}, 8'h01, "raised irq");
        wr(itt_pkg::OFS_IRQ_CLEAR, 8'h0F);
        chk({7'h0, irq}, 8'h00, "cleared irq");
        nack_at = 4'h8;
        $display("test refusal done");
    endtask : t_nack
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        t_regs;
        t_buf;
        t_unbuf;
        t_nack;
        tally_and_finish;
    end
    // The whole run needs some two thousand cycles; this is far beyond.
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
endmodule : i2c_master_tenbit_transmit_tb_top
`default_nettype wire
